//--- design/stpseq_top.sv
// phase sequencer with overcurrent off-timer and reference registers
// assumes step, direction and select are synchronous to sys_clk
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module stpseq_top (
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire logic                          step_clk,
  input  wire logic                          seq_reset,
  input  wire logic [stpseq_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire logic [stpseq_pkg::REF_W-1:0]  sense_a,
  input  wire logic [stpseq_pkg::REF_W-1:0]  sense_b,
  input  wire logic                          overcurrent_detector,
  input  wire logic                          bridge_en_in,
  output logic                               bridge_en_oe_n,
  output logic                               bridge_en_out,
  output logic                               phase_a,
  output logic                               phase_b,
  output logic                               enable_a,
  output logic                               enable_b,
  output logic                               chop_a,
  output logic                               chop_b,
  output logic      [2:0]                    state_idx
);
  import stpseq_pkg::*;

  // registers
  logic [2:0]       state_r;
  logic             step_d_r;
  logic [1:0]       ctrl_r;
  logic [REF_W-1:0] refa_r;
  logic [REF_W-1:0] refb_r;
  logic [7:0]       rdata_r;
  stpseq_prot_t     prot_r;
  logic [OFF_CNT_W-1:0] off_cnt_r;
  logic             fault_seen_r;

  stpseq_ref_if rif ();

  // decoding of controls
  wire direction_select = ctrl_r[CTRL_DIR];
  wire half_full        = ctrl_r[CTRL_HALF];
  wire step_rise        = step_clk & ~step_d_r; // RULE11
  wire state_odd        = (state_r[0] == 1'b0); // index 0 is state 1
  wire full_mode        = ~half_full; // RULE1
  // in full mode the parity is kept: move two; half mode moves one
  wire [2:0] stride     = full_mode ? TWO_IDX : ONE_IDX; // RULE2 RULE14
  wire [2:0] state_nxt  = direction_select ? 3'(state_r + stride)
                                           : 3'(state_r - stride); // RULE4 RULE5 RULE13

  // phase table, half-step order; index 0 is state 1 (both phases)
  function automatic logic [3:0] phase_map(input logic [2:0] idx);
    case (idx)
      3'h0:    phase_map = 4'b1111; // ena enb pha phb
      3'h1:    phase_map = 4'b0101;
      3'h2:    phase_map = 4'b1101;
      3'h3:    phase_map = 4'b1000;
      3'h4:    phase_map = 4'b1100;
      3'h5:    phase_map = 4'b0100;
      3'h6:    phase_map = 4'b1110;
      3'h7:    phase_map = 4'b1011;
      default: phase_map = 4'b0000;
    endcase
  endfunction : phase_map

  wire [3:0] pmap = phase_map(state_r); // RULE15

  // sequencer: one step per rising edge of the step clock
  always_ff @(posedge sys_clk) begin
    if (!rstn || seq_reset) begin
      state_r  <= HOME_IDX; // RULE12
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_clk;
      if (step_rise) state_r <= state_nxt; // RULE11
    end
  end

  // register port decode
  wire wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
  wire wr_refa = reg_wr && (reg_addr == REFA_ADDR);
  wire wr_refb = reg_wr && (reg_addr == REFB_ADDR);
  wire [7:0] rd_mux = (reg_addr == CTRL_ADDR) ? {6'h00, ctrl_r} :
                      (reg_addr == REFA_ADDR) ? refa_r :
                      (reg_addr == REFB_ADDR) ? refb_r :
                      (reg_addr == STAT_ADDR) ? {2'h0, fault_seen_r,
                                                 (prot_r == STPSEQ_OFF), 1'b0, state_r}
                                              : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r  <= CTRL_RST;
      refa_r  <= REF_RST;
      refb_r  <= REF_RST;
      rdata_r <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata[1:0];
      if (wr_refa) refa_r <= reg_wdata; // RULE6 RULE7
      if (wr_refb) refb_r <= reg_wdata; // RULE6 RULE7
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // current loops, independent per bridge
  assign rif.ref_a   = refa_r;
  assign rif.ref_b   = refb_r;
  assign rif.sense_a = sense_a;
  assign rif.sense_b = sense_b;
  stpseq_loops u_loops (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .rif     (rif)
  );
  assign chop_a = rif.trip_a;
  assign chop_b = rif.trip_b;

  // overcurrent off-timer; a new fault during off does not restart it
  wire fault_hit = overcurrent_detector; // RULE8
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prot_r       <= STPSEQ_RUN;
      off_cnt_r    <= '0;
      fault_seen_r <= 1'b0;
    end else begin
      if (fault_hit) fault_seen_r <= 1'b1; // RULE8
      else if (reg_rd && reg_addr == STAT_ADDR) fault_seen_r <= 1'b0;
      case (prot_r)
        STPSEQ_RUN: begin
          if (fault_hit) begin
            prot_r    <= STPSEQ_OFF; // RULE9
            off_cnt_r <= OFF_CNT_W'(OFF_CYCLES - 1);
          end
        end
        STPSEQ_OFF: begin
          if (off_cnt_r == '0) prot_r <= STPSEQ_RUN; // RULE10
          else off_cnt_r <= off_cnt_r - 1'b1;
        end
        default: prot_r <= STPSEQ_RUN;
      endcase
    end
  end

  // open drain: enable low means pulling the line down
  assign bridge_en_oe_n = (prot_r != STPSEQ_OFF); // RULE9
  assign bridge_en_out  = 1'b0;
  wire bridges_on = (prot_r == STPSEQ_RUN) && bridge_en_in; // RULE10

  assign enable_a  = pmap[3] & bridges_on & ~rif.trip_a;
  assign enable_b  = pmap[2] & bridges_on & ~rif.trip_b;
  assign phase_a   = pmap[1];
  assign phase_b   = pmap[0];
  assign state_idx = state_r;

  // wave and normal drive keep parity across steps
  a_full_parity: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    (step_rise && full_mode && !seq_reset) |=> (state_r[0] == $past(state_r[0])))
    else $error("full step changed parity");
  a_home_reset: assert property (@(posedge sys_clk) // RULE12
    (!rstn || seq_reset) |=> (state_r == HOME_IDX))
    else $error("reset did not go home");
  a_half_step: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
    (step_rise && half_full && direction_select && !seq_reset)
      |=> state_r == 3'($past(state_r) + ONE_IDX))
    else $error("half step not ascending");
  a_no_step_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    (!step_rise && !seq_reset) |=> $stable(state_r))
    else $error("state moved without edge");
  a_fault_off: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    (fault_hit && prot_r == STPSEQ_RUN) |=> !bridge_en_oe_n && !enable_a && !enable_b)
    else $error("fault did not disable bridges");
  a_off_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    $fell(bridge_en_oe_n) |=> !bridge_en_oe_n [*8])
    else $error("off time too short");
  a_wave_step: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    (step_rise && full_mode && !direction_select && !seq_reset)
      |=> state_r == 3'($past(state_r) - TWO_IDX))
    else $error("wave step not descending by two");
  a_map_both: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    state_odd |-> (pmap[3] && pmap[2]))
    else $error("odd state not two-phase");
endmodule : stpseq_top
`default_nettype wire

//--- design/stpseq_pkg.sv
// package for the stepper phase sequencer: states, timing and register map
// assumes a single 20 MHz clock and a plain strobe-style register port
//
// Summary of operation
// [RULE1] step-size select low means full-step operation, not half-step
// [RULE2] select low in an even state gives wave drive, one phase on
// [RULE3] host enters wave drive: reset, one step with select high, then select low
// [RULE4] from state 1 with select high, step goes to 2 (cw) or 8 (ccw)
// [RULE5] wave drive walks even states, 2-4-6-8 cw and 8-6-4-2 ccw, wrapping
// [RULE6] two independent current loops follow their own reference levels
// [RULE7] host ramps both references through fixed levels within each step period
// [RULE8] overcurrent detector hit flags a fault
// [RULE9] fault pulls bridge enable low through open-drain switch
// [RULE10] bridges stay off a fixed 400 us after a fault, then resume
// [RULE11] sequencer moves exactly one step per step clock rising edge
// [RULE12] reset and power-up place sequencer in home state 1
// [RULE13] select high steps through all eight states, ascending cw, descending ccw
// [RULE14] select low in an odd state gives normal drive, odd states, both phases
// [RULE15] each state maps to fixed phase polarity and enable outputs per bridge
package stpseq_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned OFF_TIME_US  = 400;
  localparam int unsigned OFF_CYCLES   = OFF_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OFF_CNT_W    = 14;
  localparam int unsigned REF_W        = 8;
  localparam logic [REF_W-1:0] REF_RST = 8'h00;

  // state numbers 1..8 held as 3-bit index 0..7
  localparam logic [2:0] HOME_IDX = 3'h0;
  localparam logic [2:0] ONE_IDX  = 3'h1;
  localparam logic [2:0] TWO_IDX  = 3'h2;

  // register map, word addresses on the plain register port
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  CTRL_ADDR  = 4'h0;
  localparam logic [3:0]  REFA_ADDR  = 4'h1;
  localparam logic [3:0]  REFB_ADDR  = 4'h2;
  localparam logic [3:0]  STAT_ADDR  = 4'h3;
  localparam int unsigned CTRL_DIR   = 0;
  localparam int unsigned CTRL_HALF  = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h3;

  // protection state machine, one-hot
  typedef enum logic [1:0] {
    STPSEQ_RUN  = 2'b01,
    STPSEQ_OFF  = 2'b10
  } stpseq_prot_t;
endpackage : stpseq_pkg

//--- design/stpseq_ref_if.sv
// reference levels carried from the register block to the current loops
// assumes both ends on sys_clk
`timescale 1ns/10ps
`default_nettype none
interface stpseq_ref_if;
  import stpseq_pkg::*;
  logic [REF_W-1:0] ref_a;
  logic [REF_W-1:0] ref_b;
  logic [REF_W-1:0] sense_a;
  logic [REF_W-1:0] sense_b;
  logic             trip_a;
  logic             trip_b;
  modport src  (output ref_a, output ref_b, output sense_a, output sense_b,
                input trip_a, input trip_b);
  modport loop (input ref_a, input ref_b, input sense_a, input sense_b,
                output trip_a, output trip_b);
endinterface : stpseq_ref_if
`default_nettype wire

//--- design/stpseq_loops.sv
// two independent chopper comparators, one per phase
// assumes sense levels already digitised on sys_clk
`timescale 1ns/10ps
`default_nettype none
module stpseq_loops (
  input  wire logic     sys_clk,
  input  wire logic     rstn,
  stpseq_ref_if.loop    rif
);
  import stpseq_pkg::*;
  logic trip_a_r;
  logic trip_b_r;
  wire  trip_a_nxt = (rif.sense_a > rif.ref_a); // RULE6
  wire  trip_b_nxt = (rif.sense_b > rif.ref_b); // RULE6
  // each bridge compares only against its own reference
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trip_a_r <= 1'b0;
      trip_b_r <= 1'b0;
    end else begin
      trip_a_r <= trip_a_nxt;
      trip_b_r <= trip_b_nxt;
    end
  end
  assign rif.trip_a = trip_a_r;
  assign rif.trip_b = trip_b_r;
endmodule : stpseq_loops
`default_nettype wire

//--- testbench/stpseq_host.sv
// host-side model: drives the step clock toward the sequencer
// assumes the bench calls pulse() from its main thread only
`timescale 1ns/10ps
`default_nettype none
module stpseq_host (
  input  wire logic sys_clk,
  output var logic  step_clk
);
  initial step_clk = 1'b0;
  // one rising edge per call; width and gap chosen by caller, prompt or slow
  task automatic pulse(input int hi, input int lo);
    @(posedge sys_clk) step_clk <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    step_clk <= 1'b0;
    repeat (lo) @(posedge sys_clk);
  endtask : pulse
endmodule : stpseq_host
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the phase sequencer, integer model of the states
// assumes the design package is compiled first and a pull-up on the enable line
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import stpseq_pkg::*;
  logic       sys_clk, rstn, step_clk, seq_reset, reg_wr, reg_rd, ocd, oe_n, en_out;
  logic       pa, pb, ea, eb, ca, cb;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sense_a, sense_b, rd, ra;
  logic [2:0] state_idx;
  wire logic  bridge_en_in;
  int         n_mismatch = 0, n_compared = 0, cyc = 0, mst = 0, dir = 1, half = 1, k, j;
  int         seed = 32'h0d3d;
  // pull-up wins unless the device pulls the line down
  assign bridge_en_in = oe_n ? 1'b1 : en_out;
  stpseq_host i_host (.sys_clk(sys_clk), .step_clk(step_clk));
  stpseq_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .step_clk(step_clk), .seq_reset(seq_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sense_a(sense_a), .sense_b(sense_b), .overcurrent_detector(ocd),
    .bridge_en_in(bridge_en_in), .bridge_en_oe_n(oe_n), .bridge_en_out(en_out), .phase_a(pa),
    .phase_b(pb), .enable_a(ea), .enable_b(eb), .chop_a(ca), .chop_b(cb), .state_idx(state_idx));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdreg(input logic [3:0] a);
    @(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdreg
  task automatic ctrl(input int h, input int d);
    half = h;
    dir = d;
    wr(CTRL_ADDR, {6'h00, h[0], d[0]});
  endtask : ctrl
  // model: half select steps by one, full by two keeping parity
  task automatic step(input int hi, input int lo);
    i_host.pulse(hi, lo);
    #1 mst = (mst + (dir ? 1 : 7) * (half ? 1 : 2)) % 8;
    check("state", 16'(mst), 16'(state_idx));
    check("both_on", 16'(mst % 2 == 0), 16'(ea & eb));
    check("any_on", 16'h0001, 16'(ea | eb));
    check("enable_a", 16'(mst % 4 != 1), 16'(ea));
    // polarity only matters while that bridge is energised
    check("phase_a", 16'((mst % 4 == 1) ? pa : (mst == 0 || mst > 5)), 16'(pa));
    check("phase_b", 16'((mst % 4 == 3) ? pb : (mst < 3)), 16'(pb));
  endtask : step
  task automatic home();
    @(posedge sys_clk) seq_reset <= 1'b1;
    @(posedge sys_clk) seq_reset <= 1'b0;
    @(posedge sys_clk) mst = 0;
    #1 check("home", 16'h0000, 16'(state_idx));
  endtask : home
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // whole run needs about 8500 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {rstn, seq_reset, reg_wr, reg_rd, ocd} = 5'h00;
    {reg_addr, reg_wdata, sense_a, sense_b} = 28'h0000000;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rdreg(CTRL_ADDR);
    check("ctrl_rst", 16'(CTRL_RST), 16'(rd));
    check("home_rst", 16'h0000, 16'(state_idx));
    for (k = 0; k < 8; k++) step(1, 2);
    ctrl(1, 0);
    for (k = 0; k < 8; k++) step(3, 9);
    $display("half step done");
    // wave entry both ways: home, one half step, then full select
    for (j = 0; j < 2; j++) begin
      home();
      ctrl(1, 1 - j);
      step(1, 2);
      ctrl(0, 1 - j);
      repeat (5) step(1, 2);
    end
    home();
    ctrl(0, 1);
    repeat (4) step(2, 3);
    ctrl(0, 0);
    repeat (2) step(1, 2);
    $display("full step done");
    // microstep ramp within one step period, then a random level on A with B at full scale
    for (k = 0; k < 64; k++) begin
      wr(REFA_ADDR, 8'(k * 4));
      wr(REFB_ADDR, 8'(252 - k * 4));
    end
    step(1, 2);
    ra = {1'b0, 7'($random(seed))};
    wr(REFA_ADDR, ra);
    wr(REFB_ADDR, 8'hFF);
    rdreg(REFA_ADDR);
    check("ref_a", 16'(ra), 16'(rd));
    rdreg(4'hF);
    check("unmapped", 16'h0000, 16'(rd));
    @(posedge sys_clk) sense_a <= ra + 8'h01;
    repeat (3) @(posedge sys_clk);
    #1 check("chop", 16'h0002, 16'({ca, cb}));
    @(posedge sys_clk) sense_a <= 8'h00;
    $display("references done");
    // overcurrent: off time length, retrigger ignored, bridges off
    @(posedge sys_clk) ocd <= 1'b1;
    @(posedge sys_clk) ocd <= 1'b0;
    #1 k = 0;
    while (oe_n === 1'b0 && k < 9000) begin
      @(posedge sys_clk) ocd <= (k == 3999);
      #1 k++;
      if (k == 4000) check("off_en", 16'h0000, 16'({ea, eb}));
      if (k == 4000) check("en_line", 16'h0000, 16'(bridge_en_in));
    end
    check("off_len", 16'(OFF_CYCLES), 16'(k));
    rdreg(STAT_ADDR);
    check("fault_seen", 16'h0001, 16'(rd[5]));
    $display("overcurrent done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
